/* design/simd_sub_regs.svh */
// Purpose: Constants for the packed unsigned subtract and absolute-difference unit
// Assumes: 32-bit operand words, four byte lanes, two halfword lanes
// Notes:   Definitions only
`ifndef SIMD_SUB_REGS_SVH
`define SIMD_SUB_REGS_SVH

`define WORD_W      32
`define BYTE_W      8
`define HALF_W      16
`define BYTE_LANES  4
`define HALF_LANES  2
`define GE_W        4
`define OP_W        3
`define WORD_RESET  32'h0000_0000
`define GE_RESET    4'h0

`endif

/* design/simd_sub_pkg.sv */
// Purpose: Types for the packed unsigned subtract and absolute-difference unit
// Assumes: Operation codes come from the instruction decoder
// Notes:   Nothing here is imported; use simd_sub_pkg::name
package simd_sub_pkg;

  // Operation selected by the decoder
  typedef enum logic [2:0] {
    op_none,
    op_halving_halfword_subtract,
    op_halving_byte_subtract,
    op_byte_abs_diff_sum,
    op_byte_abs_diff_sum_accumulate,
    op_packed_halfword_subtract,
    op_packed_byte_subtract
  } op_type;

endpackage

/* design/lane_result_if.sv */
// Purpose: Carries lane arithmetic results from the lane slice to the unit top
// Assumes: One producer and one consumer
// Notes:   Purely combinational bundle
`timescale 1ns/1ps
`default_nettype none
`include "simd_sub_regs.svh"

interface lane_result_if;
  logic [`WORD_W-1:0] halving_half;  // Halved halfword differences
  logic [`WORD_W-1:0] halving_byte;  // Halved byte differences
  logic [`WORD_W-1:0] packed_half;   // Wrapped halfword differences
  logic [`WORD_W-1:0] packed_byte;   // Wrapped byte differences
  logic [`WORD_W-1:0] abs_sum;       // Sum of absolute byte differences
  logic [`GE_W-1:0]   ge_half;       // Halfword no-borrow flags, lane pairs
  logic [`GE_W-1:0]   ge_byte;       // Byte no-borrow flags

  modport producer (output halving_half, halving_byte, packed_half, packed_byte, abs_sum, ge_half, ge_byte);
  modport consumer (input  halving_half, halving_byte, packed_half, packed_byte, abs_sum, ge_half, ge_byte);
endinterface

`default_nettype wire

/* design/simd_lane_slice.sv */
// Purpose: Per-lane unsigned differences, halving, flags and absolute sum
// Assumes: Operands stable for the cycle in which they are used
// Notes:   Fully combinational
`timescale 1ns/1ps
`default_nettype none
`include "simd_sub_regs.svh"

module simd_lane_slice (
  input  wire logic [`WORD_W-1:0] first_operand,
  input  wire logic [`WORD_W-1:0] second_operand,
  lane_result_if.producer         res
);

  logic [`BYTE_W-1:0] abs_byte [`BYTE_LANES];

  // ----------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < `BYTE_LANES; b++) begin : g_byte
      logic [`BYTE_W:0] diff;
      // Difference with one borrow bit kept
      assign diff = {1'b0, first_operand[b*`BYTE_W +: `BYTE_W]}
                  - {1'b0, second_operand[b*`BYTE_W +: `BYTE_W]};
      assign res.halving_byte[b*`BYTE_W +: `BYTE_W] = diff[`BYTE_W:1];
      assign res.packed_byte[b*`BYTE_W +: `BYTE_W]  = diff[`BYTE_W-1:0];
      assign res.ge_byte[b] = ~diff[`BYTE_W];
      // Absolute value of the lane difference
      assign abs_byte[b] = diff[`BYTE_W] ? (~diff[`BYTE_W-1:0] + 8'h01) : diff[`BYTE_W-1:0];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Halfword lanes
  // ----------------------------------------------------------------
  genvar h;
  generate
    for (h = 0; h < `HALF_LANES; h++) begin : g_half
      logic [`HALF_W:0] diff;
      assign diff = {1'b0, first_operand[h*`HALF_W +: `HALF_W]}
                  - {1'b0, second_operand[h*`HALF_W +: `HALF_W]};
      assign res.halving_half[h*`HALF_W +: `HALF_W] = diff[`HALF_W:1];
      assign res.packed_half[h*`HALF_W +: `HALF_W]  = diff[`HALF_W-1:0];
      assign res.ge_half[h*2 +: 2] = {2{~diff[`HALF_W]}};
    end
  endgenerate

  // Sum of the four absolute differences
  assign res.abs_sum = {24'h00_0000, abs_byte[0]} + {24'h00_0000, abs_byte[1]}
                     + {24'h00_0000, abs_byte[2]} + {24'h00_0000, abs_byte[3]};

endmodule // simd_lane_slice

`default_nettype wire

/* design/simd_sub_unit.sv */
// Purpose: Single-cycle packed unsigned subtract and absolute-difference unit
// Assumes: Decoder supplies operation, operands and condition pass each cycle
// Notes:   Results and flag updates are registered one cycle after issue
`timescale 1ns/1ps
`default_nettype none
`include "simd_sub_regs.svh"

module simd_sub_unit (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  issue_valid,
  input  wire simd_sub_pkg::op_type  op,
  input  wire logic                  cond_pass,
  input  wire logic [`WORD_W-1:0]    first_operand,
  input  wire logic [`WORD_W-1:0]    second_operand,
  input  wire logic [`WORD_W-1:0]    accumulation_operand,
  output logic                       dest_write,
  output logic [`WORD_W-1:0]         dest_data,
  output logic                       flags_write,
  output logic [`GE_W-1:0]           greater_equal_lane_flags
);

  lane_result_if res ();

  logic                dest_write_q;
  logic                dest_write_d;
  logic [`WORD_W-1:0]  dest_data_q;
  logic [`WORD_W-1:0]  dest_data_d;
  logic                flags_write_q;
  logic                flags_write_d;
  logic [`GE_W-1:0]    ge_q;
  logic [`GE_W-1:0]    ge_d;

  // Decoded selects and selected values
  logic                sel_halving_half;
  logic                sel_halving_byte;
  logic                sel_abs_sum;
  logic                sel_abs_sum_acc;
  logic                sel_packed_half;
  logic                sel_packed_byte;
  logic                take;
  logic                writes_flags;
  logic [`WORD_W-1:0]  acc_sum;
  logic [`WORD_W-1:0]  result_word;
  logic [`GE_W-1:0]    flag_word;

  // ----------------------------------------------------------------
  // Lane arithmetic
  // ----------------------------------------------------------------
  simd_lane_slice u_lanes (
    .first_operand  (first_operand),
    .second_operand (second_operand),
    .res            (res)
  );

  // Accumulating sum wraps modulo the word width, as a register add would
  assign acc_sum = res.abs_sum + accumulation_operand;

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  // One select per operation; a failed condition or idle slot selects nothing
  always_comb begin
    sel_halving_half = 1'b0;
    sel_halving_byte = 1'b0;
    sel_abs_sum      = 1'b0;
    sel_abs_sum_acc  = 1'b0;
    sel_packed_half  = 1'b0;
    sel_packed_byte  = 1'b0;
    if (issue_valid && cond_pass) begin
      case (op)
        simd_sub_pkg::op_halving_halfword_subtract: begin
          sel_halving_half = 1'b1;
        end
        simd_sub_pkg::op_halving_byte_subtract: begin
          sel_halving_byte = 1'b1;
        end
        simd_sub_pkg::op_byte_abs_diff_sum: begin
          sel_abs_sum = 1'b1;
        end
        simd_sub_pkg::op_byte_abs_diff_sum_accumulate: begin
          sel_abs_sum_acc = 1'b1;
        end
        simd_sub_pkg::op_packed_halfword_subtract: begin
          sel_packed_half = 1'b1;
        end
        simd_sub_pkg::op_packed_byte_subtract: begin
          sel_packed_byte = 1'b1;
        end
        default: begin
          sel_halving_half = 1'b0;  // Idle or unused code: nothing taken
        end
      endcase
    end
  end

  // Any select takes the slot; only the wrapped subtracts touch the flags
  assign take         = sel_halving_half | sel_halving_byte | sel_abs_sum
                      | sel_abs_sum_acc | sel_packed_half | sel_packed_byte;
  assign writes_flags = sel_packed_half | sel_packed_byte;

  // ----------------------------------------------------------------
  // Result selection
  // ----------------------------------------------------------------
  // Word written to the destination when the slot is taken
  always_comb begin
    result_word = dest_data_q;
    if (sel_halving_half) begin
      result_word = res.halving_half;
    end
    if (sel_halving_byte) begin
      result_word = res.halving_byte;
    end
    if (sel_abs_sum) begin
      result_word = res.abs_sum;
    end
    if (sel_abs_sum_acc) begin
      result_word = acc_sum;
    end
    if (sel_packed_half) begin
      result_word = res.packed_half;
    end
    if (sel_packed_byte) begin
      result_word = res.packed_byte;
    end
  end

  // ----------------------------------------------------------------
  // Lane flag selection
  // ----------------------------------------------------------------
  // Halfword subtract copies each lane's no-borrow into a flag pair
  genvar g;
  generate
    for (g = 0; g < `GE_W; g++) begin : g_flag
      assign flag_word[g] = sel_packed_half ? res.ge_half[g] : res.ge_byte[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // Destination strobe pulses for one cycle after each taken operation, flag strobe only after a taken wrapped subtract
  always_comb begin
    dest_write_d  = take;
    flags_write_d = take && writes_flags;
  end

  // Strobe registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dest_write_q  <= 1'b0;
      flags_write_q <= 1'b0;
    end else begin
      dest_write_q  <= dest_write_d;
      flags_write_q <= flags_write_d;
    end
  end

  // ----------------------------------------------------------------
  // Destination data
  // ----------------------------------------------------------------
  // Last written word stands until the next taken operation
  always_comb begin
    dest_data_d = dest_data_q;
    if (take) begin
      dest_data_d = result_word;
    end
  end

  // Destination data register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dest_data_q <= `WORD_RESET;
    end else begin
      dest_data_q <= dest_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Lane flags
  // ----------------------------------------------------------------
  // Flags move only with a taken wrapped subtract, never on a failed condition
  always_comb begin
    ge_d = ge_q;
    if (take && writes_flags) begin
      ge_d = flag_word;
    end
  end

  // Lane flag register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ge_q <= `GE_RESET;
    end else begin
      ge_q <= ge_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a register, no logic after the flops
  assign dest_write               = dest_write_q;
  assign dest_data                = dest_data_q;
  assign flags_write              = flags_write_q;
  assign greater_equal_lane_flags = ge_q;

endmodule // simd_sub_unit

`default_nettype wire

/* verification/simd_sub_sva.sv */
// Purpose: Port checks for the subtract unit
// Assumes: Results one edge after issue
// Notes:   Bound to every unit instance
`timescale 1ns/1ps
`default_nettype none
module simd_sub_sva (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 issue_valid,
  input wire simd_sub_pkg::op_type op,
  input wire logic                 cond_pass,
  input wire logic [31:0]          first_operand,
  input wire logic [31:0]          second_operand,
  input wire logic                 dest_write,
  input wire logic [31:0]          dest_data,
  input wire logic                 flags_write,
  input wire logic [3:0]           greater_equal_lane_flags
);
  // Clocking, short names, issue sequence
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire [31:0] a = first_operand;
  wire [31:0] b = second_operand;
  wire [3:0]  f = greater_equal_lane_flags;
  sequence take_s;
    issue_valid && cond_pass && op inside {[1:6]};
  endsequence
  // Strobes, flag hold and lane results
  dest_wr_a: assert property (take_s |=> dest_write) else $error("no write");
  refuse_hold_a: assert property (!cond_pass |=> !dest_write && !flags_write) else $error("refused wrote");
  flag_wr_a: assert property (take_s ##0 op > 4 |=> flags_write) else $error("no flag write");
  no_flag_a: assert property (take_s ##0 op < 5 |=> !flags_write) else $error("flag write");
  flag_hold_a: assert property (!flags_write |-> $stable(f)) else $error("flags moved");
  byte_ge_a: assert property (take_s ##0 op == 6 |=> f[3] == ($past(a[31:24]) >= $past(b[31:24])))
    else $error("byte flag");
  half_sub_a: assert property (take_s ##0 op == 5 |=> dest_data[15:0] == $past(a[15:0]) - $past(b[15:0]))
    else $error("half data");
  half_byte_a: assert property (take_s ##0 op == 2 |=> dest_data[7:0] == 8'(9'($past(a[7:0]) - $past(b[7:0])) >> 1))
    else $error("halving byte");
endmodule // simd_sub_sva
bind simd_sub_unit simd_sub_sva chk (.*);
`default_nettype wire

/* verification/decode_model.sv */
// Purpose: Decoder and register file stand-in
// Assumes: Operands are general register contents
// Notes:   Drives just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module decode_model (
  input  wire logic           core_clk,
  output simd_sub_pkg::op_type op,
  output logic                issue_valid,
  output logic                cond_pass,
  output logic [31:0]         first_operand,
  output logic [31:0]         second_operand,
  output logic [31:0]         accumulation_operand
);
  // Idle values at time zero
  initial begin
    op = simd_sub_pkg::op_none;
    {issue_valid, cond_pass, first_operand, second_operand, accumulation_operand} = '0;
  end
  // One issue per edge, never from stack or program counter
  task automatic issue(input logic [2:0] o, input logic v, c, input logic [31:0] x, y, z);
    @(posedge core_clk);
    op <= simd_sub_pkg::op_type'(o);
    issue_valid <= v;
    cond_pass <= c;
    first_operand <= x;
    second_operand <= y;
    accumulation_operand <= z;
  endtask
endmodule // decode_model
`default_nettype wire

/* verification/unsigned_simd_subtract_sad_unit_tb.sv */
// Purpose: Self-checking bench for the subtract unit
// Assumes: One issue per edge from the decoder stand-in
// Notes:   Xorshift operands from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module unsigned_simd_subtract_sad_unit_tb;
  logic                 core_clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 issue_valid, cond_pass, dest_write, flags_write;
  simd_sub_pkg::op_type op;
  logic [31:0]          first_operand, second_operand, accumulation_operand, dest_data;
  logic [3:0]           greater_equal_lane_flags;
  logic [3:0]           ge_m = 4'h0;
  logic [31:0]          seed = 32'h0000_1a8f;
  logic [37:0]          notes[$];
  logic [37:0]          got, exp_q;
  int                   num_errors = 0, comparisons = 0, cyc = 0;
  // Clock and instances
  always #2 core_clk = ~core_clk;
  simd_sub_unit DUT (.*);
  decode_model src (.*);
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected flags and result word
  function automatic logic [35:0] model(logic [2:0] o, logic [31:0] x, y, z);
    logic [31:0] r;
    logic [3:0]  g;
    logic [8:0]  d;
    logic [16:0] e;
    r = o == 4 ? z : 0;
    g = ge_m;
    for (int i = 0; i < 4; i++) begin
      d = x[8*i+:8] - y[8*i+:8];
      e = x[i/2*16+:16] - y[i/2*16+:16];
      if (o == 1) r[i/2*16+:16] = e[16:1];
      if (o == 2) r[8*i+:8] = d[8:1];
      if (o == 5) r[i/2*16+:16] = e[15:0];
      if (o == 5) g[i] = !e[16];
      if (o == 6) r[8*i+:8] = d[7:0];
      if (o == 6) g[i] = !d[8];
      if (o == 3 || o == 4) r += d[8] ? 8'(0 - d) : d[7:0];
    end
    return {g, r};
  endfunction
  // Reset, then every code back to back
  initial begin
    logic [31:0] x, y, z, r;
    logic [2:0]  o;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 800; k++) begin
      r = rnd();
      x = k % 13 ? rnd() : 0;
      y = k % 7 ? rnd() : x;
      z = rnd();
      o = 3'(k);
      src.issue(o, |r[1:0], |r[3:2], x, y, z);
      if (|r[1:0] && |r[3:2] && o % 7) begin
        notes.push_back({1'b1, o > 4, model(o, x, y, z)});
        if (o > 4) ge_m = notes[$][35:32];
      end
    end
    src.issue(0, 0, 0, 0, 0, 0);
    repeat (3) @(posedge core_clk);
    comparisons++;
    if (notes.size() != 0) begin
      num_errors++;
      $display("MISMATCH pending expected 0 seen %0d", notes.size());
    end
    final_report();
  end
  // Result watcher and hang limit
  always @(posedge core_clk) begin
    if (rst_n && (dest_write | flags_write) !== 1'b0) begin
      got = {dest_write, flags_write, greater_equal_lane_flags, dest_data};
      exp_q = notes.size() ? notes.pop_front() : 'x;
      comparisons++;
      if (got !== exp_q) begin
        num_errors++;
        $display("MISMATCH result expected %h seen %h", exp_q, got);
      end
    end
    if (++cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  // Counts and verdict
  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
endmodule // unsigned_simd_subtract_sad_unit_tb
`default_nettype wire
